// [core/mcal_math.sv]
// current, power and limit comparison arithmetic for one conversion
`timescale 1ns/100ps
`default_nettype none

module mcal_math
	import mcal_pkg::*;
#(
	parameter longint BUS_LSB_UV = 64'd1250
) (
	input wire mcal_meas_t meas,
	input wire logic [15:0] cal,
	input wire mcal_mask_t mask,
	input wire logic [15:0] limit,
	output logic [15:0] current,
	output logic [15:0] power,
	output logic ovf,
	output logic hit,
	output mcal_fn_t fn
);

	logic signed [31:0] cur_prod;
	logic signed [31:0] cur_shift;
	logic [16:0] cur_abs;
	logic [63:0] pow_wide;
	logic [63:0] pow_q;
	logic cur_ovf;

	// current scales with calibration; only the low fifteen bits count
	always_comb begin
		cur_prod = $signed(meas.sense) * $signed({1'b0, cal[14:0]});
		cur_shift = cur_prod >>> MCAL_CAL_SHIFT;
		cur_ovf = (cur_shift[31:15] != {17{1'b0}}) && (cur_shift[31:15] != {17{1'b1}});
		// saturate rather than wrap, so the sign bit stays honest
		if (cur_ovf) begin
			current = cur_shift[31] ? 16'h8000 : 16'h7FFF;
		end else begin
			current = cur_shift[15:0];
		end
	end

	// power step is 25 current steps; divide by a constant, no iteration
	always_comb begin
		cur_abs = current[15] ? 17'(-$signed({current[15], current})) : {1'b0, current};
		pow_wide = 64'(cur_abs) * 64'(meas.bus) * BUS_LSB_UV;
		pow_q = pow_wide / (64'(MCAL_POWER_RATIO) * MCAL_UV_PER_V);
		power = (pow_q > 64'h000000000000FFFF) ? 16'hFFFF : pow_q[15:0];
		ovf = cur_ovf || (pow_q > 64'h000000000000FFFF);
	end

	// highest enabled limit function wins the comparison
	always_comb begin
		if (mask.sense_over_limit_en) begin
			fn = MCAL_FN_SENSE_OVER;
		end else if (mask.sense_under_limit_en) begin
			fn = MCAL_FN_SENSE_UNDER;
		end else if (mask.bus_over_limit_en) begin
			fn = MCAL_FN_BUS_OVER;
		end else if (mask.bus_under_limit_en) begin
			fn = MCAL_FN_BUS_UNDER;
		end else if (mask.power_over_limit_en) begin
			fn = MCAL_FN_POWER_OVER;
		end else begin
			fn = MCAL_FN_NONE;
		end
	end

	// sense is signed, bus and power are magnitudes
	always_comb begin
		case (fn)
			MCAL_FN_SENSE_OVER: hit = $signed(meas.sense) > $signed(limit);
			MCAL_FN_SENSE_UNDER: hit = $signed(meas.sense) < $signed(limit);
			MCAL_FN_BUS_OVER: hit = meas.bus > limit;
			MCAL_FN_BUS_UNDER: hit = meas.bus < limit;
			MCAL_FN_POWER_OVER: hit = power > limit;
			default: hit = 1'b0;
		endcase
	end

endmodule // mcal_math

`default_nettype wire

// [core/mcal_regs.sv]
// calibration, current result and alert mask/enable register bank
`timescale 1ns/100ps
`default_nettype none

module mcal_regs
	import mcal_pkg::*;
#(
	parameter longint BUS_LSB_UV = 64'd1250
) (
	input wire logic clk,
	input wire logic rst,
	input wire mcal_req_t req,
	output logic [15:0] rdata,
	output logic rvalid,
	input wire logic conv_done,
	input wire mcal_meas_t meas,
	input wire logic cfg_wr,
	output logic alert_out,
	output logic alert_oe
);

	logic [15:0] cal_r, cal_nxt;
	logic [15:0] limit_r, limit_nxt;
	mcal_mask_t ctl_r, ctl_nxt;
	logic aff_r, aff_nxt;
	logic conv_done_flag_r, conv_done_flag_nxt;
	logic ovf_r, ovf_nxt;
	logic [15:0] sense_r, sense_nxt;
	logic [15:0] bus_r, bus_nxt;
	logic [15:0] cur_r, cur_nxt;
	logic [15:0] pow_r, pow_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;

	mcal_mask_t mask_view;
	logic [15:0] math_cur;
	logic [15:0] math_pow;
	logic math_ovf;
	logic math_hit;
	logic wr_cal, wr_mask, wr_limit, rd_mask;
	logic alert_active;

	// mask register as software reads it: enables plus live flags
	always_comb begin
		mask_view = ctl_r;
		mask_view.rsvd = 5'h00;
		mask_view.limit_hit_flag = aff_r;
		mask_view.conv_done_flag = conv_done_flag_r;
		mask_view.math_overflow_flag = ovf_r;
	end

	// arithmetic sees the incoming conversion, not the stored one
	mcal_math #(
		.BUS_LSB_UV(BUS_LSB_UV)
	) u_math (
		.meas(meas),
		.cal(cal_r),
		.mask(ctl_r),
		.limit(limit_r),
		.current(math_cur),
		.power(math_pow),
		.ovf(math_ovf),
		.hit(math_hit),
		.fn()
	);

	// address decode of the register port
	always_comb begin
		wr_cal = req.wr && (req.addr == MCAL_ADDR_CAL);
		wr_mask = req.wr && (req.addr == MCAL_ADDR_MASK);
		wr_limit = req.wr && (req.addr == MCAL_ADDR_LIMIT);
		rd_mask = req.rd && (req.addr == MCAL_ADDR_MASK);
	end

	// software-written registers
	always_comb begin
		cal_nxt = cal_r;
		limit_nxt = limit_r;
		ctl_nxt = ctl_r;
		if (wr_cal) begin
			cal_nxt = req.wdata & MCAL_CAL_WR_MASK;
		end
		if (wr_limit) begin
			limit_nxt = req.wdata;
		end
		// flag bits are hardware owned; writes to them are dropped
		if (wr_mask) begin
			ctl_nxt = mcal_mask_t'(req.wdata & MCAL_MASK_WR_MASK);
		end
	end

	// measurement results; stored only when a conversion completes
	always_comb begin
		sense_nxt = sense_r;
		bus_nxt = bus_r;
		cur_nxt = cur_r;
		pow_nxt = pow_r;
		ovf_nxt = ovf_r;
		if (conv_done) begin
			sense_nxt = meas.sense;
			bus_nxt = meas.bus;
			cur_nxt = math_cur;
			pow_nxt = math_pow;
			ovf_nxt = math_ovf;
		end
	end

	// flags: a completing conversion beats a clearing read in the same cycle
	always_comb begin
		aff_nxt = aff_r;
		conv_done_flag_nxt = conv_done_flag_r;
		if (rd_mask || cfg_wr) begin
			conv_done_flag_nxt = 1'b0;
		end
		if (conv_done) begin
			conv_done_flag_nxt = 1'b1;
		end
		if (ctl_r.alert_latch_en) begin
			if (rd_mask) begin
				aff_nxt = 1'b0;
			end
			if (conv_done && math_hit) begin
				aff_nxt = 1'b1;
			end
		end else if (conv_done) begin
			// transparent mode tracks each conversion's verdict
			aff_nxt = math_hit;
		end
	end

	// read data; the value returned is the one before any read clear
	always_comb begin
		rvalid_nxt = req.rd;
		rdata_nxt = rdata_r;
		if (req.rd) begin
			case (req.addr)
				MCAL_ADDR_SENSE: rdata_nxt = sense_r;
				MCAL_ADDR_BUS: rdata_nxt = bus_r;
				MCAL_ADDR_POWER: rdata_nxt = pow_r;
				MCAL_ADDR_CURRENT: rdata_nxt = cur_r;
				MCAL_ADDR_CAL: rdata_nxt = cal_r;
				MCAL_ADDR_MASK: rdata_nxt = mask_view;
				MCAL_ADDR_LIMIT: rdata_nxt = limit_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	// single register stage for the whole bank
	always_ff @(posedge clk) begin
		if (rst) begin
			cal_r <= MCAL_CAL_RST;
			limit_r <= MCAL_LIMIT_RST;
			ctl_r <= mcal_mask_t'(MCAL_MASK_RST);
			aff_r <= 1'b0;
			conv_done_flag_r <= 1'b0;
			ovf_r <= 1'b0;
			sense_r <= MCAL_RESULT_RST;
			bus_r <= MCAL_RESULT_RST;
			cur_r <= MCAL_RESULT_RST;
			pow_r <= MCAL_RESULT_RST;
			rdata_r <= 16'h0000;
			rvalid_r <= 1'b0;
		end else begin
			cal_r <= cal_nxt;
			limit_r <= limit_nxt;
			ctl_r <= ctl_nxt;
			aff_r <= aff_nxt;
			conv_done_flag_r <= conv_done_flag_nxt;
			ovf_r <= ovf_nxt;
			sense_r <= sense_nxt;
			bus_r <= bus_nxt;
			cur_r <= cur_nxt;
			pow_r <= pow_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// open-drain alert: pin only ever pulled low, so the enable carries it
	always_comb begin
		alert_active = aff_r || (ctl_r.conv_done_alert_en && conv_done_flag_r);
		alert_out = 1'b0;
		alert_oe = alert_active ^ ctl_r.alert_polarity_sel;
		rdata = rdata_r;
		rvalid = rvalid_r;
	end

	// helper for the power scaling check
	logic [63:0] chk_abs;
	logic [63:0] chk_lo;
	logic [63:0] chk_hi;
	always_comb begin
		chk_abs = cur_r[15] ? 64'(-$signed({1'b1, cur_r})) : 64'(cur_r);
		chk_lo = 64'(pow_r) * 64'(MCAL_POWER_RATIO) * MCAL_UV_PER_V;
		chk_hi = chk_lo + 64'(MCAL_POWER_RATIO) * MCAL_UV_PER_V;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_cur_sign: assert property (cur_r[15] |-> sense_r[15])
		else $error("negative current without negative sense");
	a_cal_msb: assert property (wr_cal |=> (cal_r[15] == 1'b0) && (cal_r[14:0] == $past(req.wdata[14:0])))
		else $error("calibration write stored wrongly");
	a_cal_zero: assert property (conv_done && (cal_r == 16'h0000) && !wr_cal |=> cur_r == 16'h0000)
		else $error("zero calibration gave nonzero current");
	a_power_step: assert property (!ovf_r && !$stable(pow_r) |-> (chk_abs * 64'(bus_r) * BUS_LSB_UV >= chk_lo) && (chk_abs * 64'(bus_r) * BUS_LSB_UV < chk_hi))
		else $error("power step not 25 current steps");
	a_pin_map: assert property (conv_done |=> !(ctl_r.conv_done_alert_en && !ctl_r.alert_polarity_sel) || alert_oe)
		else $error("conversion ready did not reach alert pin");
	a_prio_sov: assert property (conv_done && !ctl_r.alert_latch_en && ctl_r.sense_over_limit_en && !($signed(meas.sense) > $signed(limit_r)) |=> !aff_r)
		else $error("lower priority function raised flag");
	a_sense_over: assert property (conv_done && ctl_r.sense_over_limit_en && ($signed(meas.sense) > $signed(limit_r)) |=> aff_r)
		else $error("sense over limit missed");
	a_sense_under: assert property (conv_done && !ctl_r.sense_over_limit_en && ctl_r.sense_under_limit_en && ($signed(meas.sense) < $signed(limit_r)) |=> aff_r)
		else $error("sense under limit missed");
	a_bus_over: assert property (conv_done && (ctl_r[15:14] == 2'b00) && ctl_r.bus_over_limit_en && (meas.bus > limit_r) |=> aff_r)
		else $error("bus over limit missed");
	a_bus_under: assert property (conv_done && (ctl_r[15:13] == 3'b000) && ctl_r.bus_under_limit_en && (meas.bus < limit_r) |=> aff_r)
		else $error("bus under limit missed");
	a_latch_hold: assert property (aff_r && ctl_r.alert_latch_en && !rd_mask && !wr_mask |=> aff_r)
		else $error("latched flag dropped without read");
	a_polarity: assert property (aff_r && !ctl_r.alert_polarity_sel |-> alert_oe ##0 (alert_out == 1'b0))
		else $error("normal polarity not pulling low");

	c_sense_alert: cover property (conv_done && ctl_r.sense_over_limit_en ##1 aff_r);
	c_latch_clear: cover property (aff_r && ctl_r.alert_latch_en ##1 rd_mask ##1 !aff_r);
	c_inverted: cover property (ctl_r.alert_polarity_sel && aff_r && !alert_oe);
	c_conv_ready: cover property (ctl_r.conv_done_alert_en && conv_done_flag_r && !aff_r);

endmodule // mcal_regs

`default_nettype wire

// [shared/mcal_pkg.sv]
// constants and carrier types of the monitor calibration and alert register bank
`default_nettype none

package mcal_pkg;

	// word width of every register
	localparam int MCAL_DW = 16;

	// register addresses on the serial register port
	localparam logic [7:0] MCAL_ADDR_SENSE = 8'h01;
	localparam logic [7:0] MCAL_ADDR_BUS = 8'h02;
	localparam logic [7:0] MCAL_ADDR_POWER = 8'h03;
	localparam logic [7:0] MCAL_ADDR_CURRENT = 8'h04;
	localparam logic [7:0] MCAL_ADDR_CAL = 8'h05;
	localparam logic [7:0] MCAL_ADDR_MASK = 8'h06;
	localparam logic [7:0] MCAL_ADDR_LIMIT = 8'h07;

	// reset values
	localparam logic [15:0] MCAL_CAL_RST = 16'h0000;
	localparam logic [15:0] MCAL_MASK_RST = 16'h0000;
	localparam logic [15:0] MCAL_LIMIT_RST = 16'h0000;
	localparam logic [15:0] MCAL_RESULT_RST = 16'h0000;

	// writable bits: calibration top bit is held at zero
	localparam logic [15:0] MCAL_CAL_WR_MASK = 16'h7FFF;
	// writable bits of mask/enable: enables 15..10, polarity 1, latch 0
	localparam logic [15:0] MCAL_MASK_WR_MASK = 16'hFC03;

	// current = sense * calibration >> shift
	localparam int MCAL_CAL_SHIFT = 11;
	// power step is this many current steps
	localparam int MCAL_POWER_RATIO = 25;
	// microvolts per volt, for the power scaling
	localparam longint MCAL_UV_PER_V = 64'd1000000;

	// mask/enable register layout, bit 15 first
	typedef struct packed {
		logic sense_over_limit_en;
		logic sense_under_limit_en;
		logic bus_over_limit_en;
		logic bus_under_limit_en;
		logic power_over_limit_en;
		logic conv_done_alert_en;
		logic [4:0] rsvd;
		logic limit_hit_flag;
		logic conv_done_flag;
		logic math_overflow_flag;
		logic alert_polarity_sel;
		logic alert_latch_en;
	} mcal_mask_t;

	// one completed conversion from the analog side
	typedef struct packed {
		logic [15:0] sense;
		logic [15:0] bus;
	} mcal_meas_t;

	// one register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} mcal_req_t;

	// limit function that currently owns the comparison
	typedef enum logic [2:0] {
		MCAL_FN_NONE,
		MCAL_FN_SENSE_OVER,
		MCAL_FN_SENSE_UNDER,
		MCAL_FN_BUS_OVER,
		MCAL_FN_BUS_UNDER,
		MCAL_FN_POWER_OVER
	} mcal_fn_t;

endpackage

`default_nettype wire

// [tb/mcal_conv_src.sv]
// conversion source model feeding completed measurements to the register bank
`timescale 1ns/100ps
`default_nettype none

module mcal_conv_src
	import mcal_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic [15:0] sense_in,
	input wire logic [15:0] bus_in,
	output logic conv_done,
	output mcal_meas_t meas
);
	logic conv_done_r;
	mcal_meas_t meas_r;

	// one pulse per request; results scramble between conversions
	// so a design that samples them late cannot get lucky
	always_ff @(posedge clk) begin
		if (rst) begin
			conv_done_r <= 1'b0;
			meas_r <= '0;
		end else begin
			conv_done_r <= go;
			meas_r <= go ? {sense_in, bus_in} : ~meas_r;
		end
	end

	assign conv_done = conv_done_r;
	assign meas = meas_r;
endmodule // mcal_conv_src

`default_nettype wire

// [tb/mcal_regs_bench.sv]
// self-checking bench for the calibration and alert register bank
`timescale 1ns/100ps
`default_nettype none

module mcal_regs_bench
	import mcal_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	logic cfg_wr = 1'b0;
	logic [15:0] s_in = 16'h0000;
	logic [15:0] b_in = 16'h0000;
	mcal_req_t req = '0;
	logic [15:0] rdata;
	logic rvalid;
	logic conv_done;
	mcal_meas_t meas;
	logic alert_out;
	logic alert_oe;
	logic [15:0] v;
	int error_cnt = 0;
	int n_tests = 0;
	int cycles = 0;
	// limit function table, limit is 16'h0100
	logic [15:0] en_t [4] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000};
	logic [15:0] hs_t [4] = '{16'h0101, 16'hFF00, 16'h0100, 16'h0100};
	logic [15:0] hb_t [4] = '{16'h0100, 16'h0100, 16'h0101, 16'h00FF};

	always #5 clk = ~clk;

	// 25 mV bus lsb so power comes out as current * bus / 1000 exactly
	mcal_regs #(.BUS_LSB_UV(64'd25000)) u_mcal_regs (
		.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
		.conv_done(conv_done), .meas(meas), .cfg_wr(cfg_wr),
		.alert_out(alert_out), .alert_oe(alert_oe));

	mcal_conv_src u_mcal_conv_src (
		.clk(clk), .rst(rst), .go(go), .sense_in(s_in), .bus_in(b_in),
		.conv_done(conv_done), .meas(meas));

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic chk_oe(input logic e);
		chk({15'h0000, alert_oe}, {15'h0000, e});
		chk({15'h0000, alert_out}, 16'h0000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask

	// answer lands one cycle after the request edge
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		req <= '0;
		#1;
		chk({15'h0000, rvalid}, 16'h0001);
		d = rdata;
	endtask

	// request, model pulse, design capture, then let alert settle
	task automatic conv(input logic [15:0] s, input logic [15:0] b);
		@(posedge clk);
		s_in <= s;
		b_in <= b;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// hang guard, the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(MCAL_ADDR_CAL, v);
		chk(v, MCAL_CAL_RST);
		rd(MCAL_ADDR_MASK, v);
		chk(v, MCAL_MASK_RST);
		chk_oe(1'b0);
		wr(MCAL_ADDR_CAL, 16'hFFFF);
		rd(MCAL_ADDR_CAL, v);
		chk(v, 16'h7FFF);
		wr(MCAL_ADDR_MASK, 16'hFFFF);
		rd(MCAL_ADDR_MASK, v);
		chk(v, 16'hFC03);
		chk_oe(1'b1);
		wr(MCAL_ADDR_MASK, 16'h0000);
		wr(MCAL_ADDR_LIMIT, 16'h0100);
		rd(8'h20, v);
		chk(v, 16'h0000);
		$display("test reset and access done");

		wr(MCAL_ADDR_CAL, 16'h0800);
		conv(16'hFF00, 16'h03E8);
		rd(MCAL_ADDR_CURRENT, v);
		chk(v, 16'hFF00);
		rd(MCAL_ADDR_POWER, v);
		chk(v, 16'h0100);
		wr(MCAL_ADDR_CAL, 16'h1000);
		conv(16'h0100, 16'h03E8);
		wr(MCAL_ADDR_CURRENT, 16'h1234);
		rd(MCAL_ADDR_CURRENT, v);
		chk(v, 16'h0200);
		rd(MCAL_ADDR_POWER, v);
		chk(v, 16'h0200);
		$display("test calibration done");

		// hit then an equal-to-limit miss for each of the four sense and bus functions
		for (int i = 0; i < 4; i++) begin
			wr(MCAL_ADDR_MASK, en_t[i]);
			conv(hs_t[i], hb_t[i]);
			chk_oe(1'b1);
			conv(16'h0100, 16'h0100);
			chk_oe(1'b0);
		end
		wr(MCAL_ADDR_MASK, 16'hA000);
		conv(16'h0100, 16'h0200);
		chk_oe(1'b0);
		wr(MCAL_ADDR_MASK, 16'h2000);
		conv(16'h0100, 16'h0200);
		chk_oe(1'b1);
		conv(16'h0100, 16'h0100);
		$display("test limit functions done");

		wr(MCAL_ADDR_MASK, 16'h8001);
		conv(16'h0200, 16'h0100);
		conv(16'h0100, 16'h0100);
		chk_oe(1'b1);
		rd(MCAL_ADDR_MASK, v);
		chk(v & 16'h0010, 16'h0010);
		chk_oe(1'b0);
		wr(MCAL_ADDR_MASK, 16'h8002);
		conv(16'h0200, 16'h0100);
		chk_oe(1'b0);
		conv(16'h0100, 16'h0100);
		chk_oe(1'b1);
		wr(MCAL_ADDR_MASK, 16'h0400);
		conv(16'h0100, 16'h0100);
		chk_oe(1'b1);
		@(posedge clk);
		cfg_wr <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
		#1;
		chk_oe(1'b0);
		$display("test latch and polarity done");

		// power function alone, then a saturating conversion
		wr(MCAL_ADDR_MASK, 16'h0800);
		conv(16'h0100, 16'h03E8);
		chk_oe(1'b1);
		wr(MCAL_ADDR_CAL, 16'h7FFF);
		conv(16'h7FFF, 16'h0100);
		rd(MCAL_ADDR_CURRENT, v);
		chk(v, 16'h7FFF);
		rd(MCAL_ADDR_MASK, v);
		chk(v, 16'h081C);
		chk_oe(1'b1);
		$display("test power and overflow done");

		// reset in mid-run while the alert is active
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(MCAL_ADDR_CAL, v);
		chk(v, MCAL_CAL_RST);
		rd(MCAL_ADDR_MASK, v);
		chk(v, MCAL_MASK_RST);
		chk_oe(1'b0);
		conv(16'h7FFF, 16'h0100);
		rd(MCAL_ADDR_CURRENT, v);
		chk(v, 16'h0000);
		$display("test mid-run reset done");
		stop_test();
	end
endmodule // mcal_regs_bench

`default_nettype wire
